// file: bench/camera_sync_source.sv
// Purpose: Camera-side sync source for the output sequencer bench.
// Assumes: Line and field sync fall in the same cycle at field start.
// Notes: Short fields keep the run brief.
`timescale 1ns/100ps
`default_nettype none
module camera_sync_source #(
   parameter int PIX = 16,
   parameter int LINES = 5
) (
   input wire logic sys_clk,
   input wire logic rst,
   output logic vertical_sync,
   output logic line_sync
);
   // Position within the field
   int cnt_reg = 0;
   // Free-running field position, restarted by reset
   always_ff @(posedge sys_clk) begin
      cnt_reg <= (rst || cnt_reg == PIX * LINES - 1) ? 0 : cnt_reg + 1;
   end
   // Field sync low through line zero, so it falls once per field
   assign vertical_sync = cnt_reg >= PIX;
   // Line sync low two pixels; falls with field sync, never just before
   assign line_sync = (cnt_reg % PIX) >= 2;
endmodule // camera_sync_source
`default_nettype wire

// file: bench/field_toggle_output_sequencer_sva.sv
// Purpose: Port-level checks for the field toggle output sequencer.
// Assumes: Field boundary is the sampled fall of vertical sync.
// Notes: Shadows of protocol and trigger writes drive the checks.
`timescale 1ns/100ps
`default_nettype none
module field_toggle_output_sequencer_chk (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic vertical_sync,
   input wire logic line_sync,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic general_output_one,
   input wire logic general_output_two
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // Helper state
   logic vs_q, trig_w, armed;
   logic [13:0] prot_q;
   logic [1:0] idle_f;
   wire logic vfall = vs_q && !vertical_sync;
   wire logic rd_go = clk_en && reg_rd;
   wire logic prot_wr = clk_en && reg_wr &&
      reg_addr == gpo_seq_pkg::ADDR_PROTOCOL;
   wire logic mapped = reg_addr inside {[8'h50:8'h52], [8'h54:8'h5A]};
   // Tracked through reset too, so release never fakes a boundary
   always_ff @(posedge sys_clk) vs_q <= vertical_sync;
   // Protocol shadow
   always_ff @(posedge sys_clk) begin
      if (rst) prot_q <= 14'h0000;
      else if (prot_wr) prot_q <= reg_wdata[13:0];
   end
   // Trigger written in this field; the boundary wins
   always_ff @(posedge sys_clk) begin
      if (rst || vfall) trig_w <= 1'b0;
      else if (clk_en && reg_wr && reg_addr == gpo_seq_pkg::ADDR_TRIGGER)
         trig_w <= 1'b1;
   end
   // Boundaries seen with both selectors idle, saturating at two
   always_ff @(posedge sys_clk) begin
      if (rst || prot_q[3:0] != 4'h0) idle_f <= 2'h0;
      else if (vfall && idle_f != 2'h2) idle_f <= idle_f + 2'h1;
   end
   // Manual armed from a settled idle, until the next boundary
   always_ff @(posedge sys_clk) begin
      if (rst || vfall) armed <= 1'b0;
      else if (prot_wr && idle_f == 2'h2 && reg_wdata[1:0] == 2'h1 &&
         !reg_wdata[8]) armed <= 1'b1;
   end
   chk_reset_quiet: assert property (
      $fell(rst) |-> reg_rdata == 32'h0000_0000 && !general_output_one &&
      !general_output_two) else $error("outputs not quiet after reset");
   chk_rdata_idle: assert property (
      clk_en && !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data not zero outside a read");
   chk_unmapped_zero: assert property (
      rd_go && !mapped |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read returned data");
   chk_table_readback: assert property (
      rd_go && reg_addr == gpo_seq_pkg::ADDR_PROTOCOL |=>
      reg_rdata[13:0] == prot_q) else $error("protocol readback wrong");
   chk_trigger_clears: assert property (
      rd_go && reg_addr == gpo_seq_pkg::ADDR_TRIGGER && !trig_w |=>
      reg_rdata[2:0] == 3'h0) else $error("trigger not cleared");
   chk_idle_low: assert property (
      idle_f == 2'h2 && prot_q[9:8] == 2'h0 && $past(prot_q[9:8]) == 2'h0
      |-> !general_output_one && !general_output_two)
      else $error("output active while idle");
   chk_manual_waits: assert property (
      armed |-> !general_output_one)
      else $error("manual toggle in the field of the write");
   chk_status_waves: assert property (
      rd_go && reg_addr == gpo_seq_pkg::ADDR_STATUS && idle_f == 2'h2 |=>
      reg_rdata[9:8] == 2'h0) else $error("wave high while idle");
   cov_manual_armed: cover property (armed ##1 !armed);
   cov_trigger_write: cover property (
      clk_en && reg_wr && reg_addr == gpo_seq_pkg::ADDR_TRIGGER);
   cov_idle_status: cover property (
      rd_go && reg_addr == gpo_seq_pkg::ADDR_STATUS && idle_f == 2'h2);
endmodule // field_toggle_output_sequencer_chk
bind field_toggle_output_sequencer field_toggle_output_sequencer_chk u_chk (
   .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
   .vertical_sync(vertical_sync), .line_sync(line_sync),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .general_output_one(general_output_one),
   .general_output_two(general_output_two));
`default_nettype wire

// file: bench/field_toggle_output_sequencer_test.sv
// Purpose: Self-checking bench for the field toggle output sequencer.
// Assumes: Sync source gives five lines of sixteen pixels per field.
// Notes: Pins are sampled mid-line, clear of toggle edges.
`timescale 1ns/100ps
`default_nettype none
module field_toggle_output_sequencer_test;
   localparam int PIX = 16;
   localparam int LINES = 5;
   logic sys_clk, rst, clk_en, reg_wr, reg_rd, vs_q;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd_val;
   logic general_output_one, general_output_two, vertical_sync, line_sync;
   logic [3:0] luts [4];
   int pos = 0;
   int mismatches, tests_run;
   camera_sync_source #(.PIX(PIX), .LINES(LINES)) u_camera_sync_source (
      .sys_clk(sys_clk), .rst(rst), .vertical_sync(vertical_sync),
      .line_sync(line_sync));
   field_toggle_output_sequencer u_field_toggle_output_sequencer (
      .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
      .vertical_sync(vertical_sync), .line_sync(line_sync),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .general_output_one(general_output_one),
      .general_output_two(general_output_two));
   // Clock, 20 ns period
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Cycle position in the field, zero at the boundary
   always @(posedge sys_clk) begin
      vs_q <= vertical_sync;
      pos <= (vs_q && !vertical_sync) ? 0 : pos + 1;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   // Falling clock edge keeps sampling away from updates
   task automatic at(input int c);
      do @(negedge sys_clk); while (pos != c);
   endtask
   // Pins at lines 1 to 4; waves high on lines 1-2 and 2-3
   task automatic chk_lines(input logic [3:0] logic_table, input logic tab,
      input logic on);
      logic [1:0] w;
      for (int l = 1; l < LINES; l++) begin
         w = on ? {l == 2 || l == 3, l == 1 || l == 2} : 2'b00;
         at(l * PIX + 9);
         check({30'h0, general_output_two, general_output_one},
            {30'h0, w[1], tab ? logic_table[w] : w[0]});
      end
   endtask
   // One counter field: output one high from count 2 line 1 to count 3
   task automatic fld(input gpo_seq_pkg::counter_e st, input logic [3:0] n);
      logic run;
      run = st == gpo_seq_pkg::CNT_RUN;
      at(0);
      at(9);
      check({31'h0, general_output_one}, {31'h0, run && n == 4'h3});
      at(2 * PIX + 9);
      check({31'h0, general_output_one}, {31'h0, run && n == 4'h2});
      rd(gpo_seq_pkg::ADDR_TRIGGER);
      check(rd_val, 32'h0000_0000);
      rd(gpo_seq_pkg::ADDR_STATUS);
      check({26'h0, rd_val[7:4] & {4{run}}, rd_val[3:2]},
         {26'h0, n & {4{run}}, st});
   endtask
   task automatic wrap_up;
      if (mismatches == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Some 27 fields of 80 cycles are expected; allow a wide margin
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      mismatches = 0;
      tests_run = 0;
      luts = '{4'h6, 4'h7, 4'h8, 4'hE};
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(gpo_seq_pkg::ADDR_PROTOCOL);
      check(rd_val, gpo_seq_pkg::PROTOCOL_RST);
      rd(8'h53);
      check(rd_val, 32'h0000_0000);
      wr(8'h54, 32'h0400_2000);
      wr(8'h55, 32'h0400_6000);
      wr(8'h56, 32'h0400_4000);
      wr(8'h57, 32'h0400_8000);
      at(0);
      at(0);
      wr(gpo_seq_pkg::ADDR_PROTOCOL, 32'h0000_0005);
      chk_lines(4'h0, 1'b0, 1'b0);
      at(0);
      chk_lines(4'h0, 1'b0, 1'b1);
      for (int i = 0; i < 4; i++) begin
         wr(gpo_seq_pkg::ADDR_PROTOCOL, {18'h0, luts[i], 10'h105});
         rd(gpo_seq_pkg::ADDR_PROTOCOL);
         check(rd_val, {18'h0, luts[i], 10'h105});
         at(0);
         chk_lines(luts[i], 1'b1, 1'b1);
      end
      wr(gpo_seq_pkg::ADDR_PROTOCOL, 32'h0000_0000);
      at(0);
      chk_lines(4'h0, 1'b0, 1'b0);
      at(0);
      rd(gpo_seq_pkg::ADDR_STATUS);
      check({30'h0, rd_val[9:8]}, 32'h0000_0000);
      wr(8'h54, 32'h0800_2000);
      wr(8'h55, 32'h0C00_2000);
      wr(gpo_seq_pkg::ADDR_COUNTER, 32'h0000_0003);
      wr(gpo_seq_pkg::ADDR_PROTOCOL, 32'h0000_0002);
      wr(gpo_seq_pkg::ADDR_TRIGGER, {29'h0, gpo_seq_pkg::ACT_SINGLE});
      rd(gpo_seq_pkg::ADDR_TRIGGER);
      check(rd_val, 32'h0000_0001);
      for (int i = 1; i < 4; i++) fld(gpo_seq_pkg::CNT_RUN, 4'(i));
      fld(gpo_seq_pkg::CNT_IDLE, 4'h0);
      wr(gpo_seq_pkg::ADDR_COUNTER, 32'h0000_0013);
      wr(gpo_seq_pkg::ADDR_TRIGGER, {29'h0, gpo_seq_pkg::ACT_DELAYED});
      fld(gpo_seq_pkg::CNT_DELAY, 4'h0);
      for (int i = 1; i < 4; i++) fld(gpo_seq_pkg::CNT_RUN, 4'(i));
      fld(gpo_seq_pkg::CNT_IDLE, 4'h0);
      // idle for a whole field before rearming
      wr(gpo_seq_pkg::ADDR_PROTOCOL, 32'h0000_0000);
      at(0);
      at(0);
      wr(gpo_seq_pkg::ADDR_COUNTER, 32'h0000_0003);
      wr(gpo_seq_pkg::ADDR_PROTOCOL, 32'h0000_0003);
      wr(gpo_seq_pkg::ADDR_TRIGGER, {29'h0, gpo_seq_pkg::ACT_WRAP});
      for (int i = 0; i < 6; i++) begin
         fld(gpo_seq_pkg::CNT_RUN, 4'(i % 3 + 1));
      end
      wr(gpo_seq_pkg::ADDR_TRIGGER, {29'h0, gpo_seq_pkg::ACT_FORCE_IDLE});
      fld(gpo_seq_pkg::CNT_IDLE, 4'h0);
      // Frozen clock enable drops a write; protocol keeps repeat value
      clk_en <= 1'b0;
      wr(gpo_seq_pkg::ADDR_PROTOCOL, 32'h0000_0005);
      clk_en <= 1'b1;
      rd(gpo_seq_pkg::ADDR_PROTOCOL);
      check(rd_val, 32'h0000_0003);
      wrap_up();
   end
endmodule // field_toggle_output_sequencer_test
`default_nettype wire

// file: hw/field_toggle_output_sequencer.sv
// Purpose: Two field-placed output waveforms with a pair logic table.
// Assumes: Vertical sync and line sync are synchronous to sys_clk.
// Notes: Line sync falling edge restarts the pixel count.
`timescale 1ns/100ps
`default_nettype none
module field_toggle_output_sequencer (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic vertical_sync,
   input wire logic line_sync,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic general_output_one,
   output logic general_output_two
);
   // Software registers
   logic [2:0] trigger_reg;
   logic [7:0] counter_cfg_reg;
   logic [31:0] protocol_reg;
   gpo_seq_pkg::toggle_s tog_reg [0:5];
   // Field timing
   logic vsync_d_reg;
   logic hsync_d_reg;
   logic [12:0] line_reg;
   logic [12:0] pixel_reg;
   // Primary counter
   gpo_seq_pkg::counter_e cnt_state_reg;
   gpo_seq_pkg::counter_e cnt_state_next;
   logic [3:0] field_cnt_reg;
   logic [3:0] field_cnt_next;
   logic [3:0] delay_cnt_reg;
   logic [3:0] delay_cnt_next;
   logic wrap_reg;
   logic wrap_next;
   // Decode and selection
   wire field_start;
   wire line_start;
   wire [3:0] cnt_max;
   wire [3:0] cnt_delay;
   wire [3:0] pair_logic_table;
   wire [1:0] sel_table;
   wire wave_one;
   wire wave_two;
   wire table_out;
   wire wr_tog;
   wire [2:0] tog_idx;
   wire [7:0] tog_off;
   wire gpo_seq_pkg::position_s pos;
   wire gpo_seq_pkg::protocol_e output_one_sequence_select;
   wire gpo_seq_pkg::protocol_e output_two_sequence_select;
   wire [31:0] rd_mux;
   wire [31:0] tog_word;

   assign field_start = vsync_d_reg && !vertical_sync;
   assign line_start = hsync_d_reg && !line_sync;
   assign cnt_max = counter_cfg_reg[gpo_seq_pkg::MAX_LSB +: 4];
   assign cnt_delay = counter_cfg_reg[gpo_seq_pkg::DELAY_LSB +: 4];
   assign pair_logic_table = protocol_reg[gpo_seq_pkg::LUT_LSB +: 4];
   assign sel_table = protocol_reg[gpo_seq_pkg::SEL_LUT_LSB +: 2];
   assign output_one_sequence_select =
      gpo_seq_pkg::protocol_e'(protocol_reg[gpo_seq_pkg::PROT1_LSB +: 2]);
   assign output_two_sequence_select =
      gpo_seq_pkg::protocol_e'(protocol_reg[gpo_seq_pkg::PROT2_LSB +: 2]);
   assign pos = '{line: line_reg, pixel: pixel_reg, field: field_cnt_reg,
                  field_start: field_start};
   assign tog_off = reg_addr - gpo_seq_pkg::ADDR_TOG_BASE;
   assign tog_idx = tog_off[2:0];
   assign wr_tog = reg_wr && reg_addr >= gpo_seq_pkg::ADDR_TOG_BASE &&
                   reg_addr <= gpo_seq_pkg::ADDR_TOG_LAST;
   assign tog_word = (reg_addr >= gpo_seq_pkg::ADDR_TOG_BASE &&
                      reg_addr <= gpo_seq_pkg::ADDR_TOG_LAST) ?
                     {2'b00, tog_reg[tog_idx]} : 32'h0000_0000;

   assign table_out = pair_logic_table[{wave_two, wave_one}];

   // Read selection, unmapped reads zero
   assign rd_mux =
      (reg_addr == gpo_seq_pkg::ADDR_TRIGGER) ? {29'd0, trigger_reg} :
      (reg_addr == gpo_seq_pkg::ADDR_COUNTER) ? {24'd0, counter_cfg_reg} :
      (reg_addr == gpo_seq_pkg::ADDR_PROTOCOL) ? protocol_reg :
      (reg_addr == gpo_seq_pkg::ADDR_STATUS) ?
         {22'd0, wave_two, wave_one, field_cnt_reg, cnt_state_reg,
          wrap_reg, 1'b0} :
      tog_word;

   // Register writes and read data
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         trigger_reg <= gpo_seq_pkg::ACT_IDLE;
         counter_cfg_reg <= gpo_seq_pkg::COUNTER_RST;
         protocol_reg <= gpo_seq_pkg::PROTOCOL_RST;
         reg_rdata <= 32'h0000_0000;
         for (int i = 0; i < 6; i++) begin
            tog_reg[i] <= gpo_seq_pkg::toggle_s'(gpo_seq_pkg::TOGGLE_RST);
         end
      end else if (clk_en) begin
         if (field_start) begin
            trigger_reg <= gpo_seq_pkg::ACT_IDLE;
         end else if (reg_wr && reg_addr == gpo_seq_pkg::ADDR_TRIGGER) begin
            trigger_reg <= reg_wdata[2:0];
         end
         if (reg_wr && reg_addr == gpo_seq_pkg::ADDR_COUNTER) begin
            counter_cfg_reg <= reg_wdata[7:0];
         end
         if (reg_wr && reg_addr == gpo_seq_pkg::ADDR_PROTOCOL) begin
            protocol_reg <= {18'd0, reg_wdata[13:0]};
         end
         if (wr_tog) begin
            tog_reg[tog_idx] <= reg_wdata[29:0];
         end
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   // Line and pixel position counters
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         vsync_d_reg <= 1'b1;
         hsync_d_reg <= 1'b1;
         line_reg <= 13'h0000;
         pixel_reg <= 13'h0000;
      end else if (clk_en) begin
         vsync_d_reg <= vertical_sync;
         hsync_d_reg <= line_sync;
         if (field_start) begin
            line_reg <= 13'h0000;
            pixel_reg <= 13'h0000;
         end else if (line_start) begin
            line_reg <= line_reg + 13'h0001;
            pixel_reg <= 13'h0000;
         end else begin
            pixel_reg <= pixel_reg + 13'h0001;
         end
      end
   end

   // Primary field counter, stepped at boundaries
   always_comb begin
      cnt_state_next = cnt_state_reg;
      field_cnt_next = field_cnt_reg;
      delay_cnt_next = delay_cnt_reg;
      wrap_next = wrap_reg;
      if (field_start) begin
         case (cnt_state_reg)
            gpo_seq_pkg::CNT_RUN: begin
               if (field_cnt_reg >= cnt_max) begin
                  if (wrap_reg) begin
                     field_cnt_next = 4'h1;
                  end else begin
                     cnt_state_next = gpo_seq_pkg::CNT_IDLE;
                     field_cnt_next = 4'h0;
                  end
               end else begin
                  field_cnt_next = field_cnt_reg + 4'h1;
               end
            end
            gpo_seq_pkg::CNT_DELAY: begin
               if (delay_cnt_reg == 4'h0) begin
                  cnt_state_next = gpo_seq_pkg::CNT_RUN;
                  field_cnt_next = 4'h1;
               end else begin
                  delay_cnt_next = delay_cnt_reg - 4'h1;
               end
            end
            default: begin
               field_cnt_next = 4'h0;
            end
         endcase
         // Trigger acts at boundary, ahead of counting
         case (trigger_reg)
            gpo_seq_pkg::ACT_SINGLE: begin
               cnt_state_next = gpo_seq_pkg::CNT_RUN;
               field_cnt_next = 4'h1;
               wrap_next = 1'b0;
            end
            gpo_seq_pkg::ACT_WRAP: begin
               cnt_state_next = gpo_seq_pkg::CNT_RUN;
               field_cnt_next = 4'h1;
               wrap_next = 1'b1;
            end
            gpo_seq_pkg::ACT_DELAYED: begin
               // Delay of zero starts running at this boundary
               cnt_state_next = gpo_seq_pkg::CNT_DELAY;
               delay_cnt_next = cnt_delay - 4'h1;
               field_cnt_next = 4'h0;
               wrap_next = 1'b0;
               if (cnt_delay == 4'h0) begin
                  cnt_state_next = gpo_seq_pkg::CNT_RUN;
                  field_cnt_next = 4'h1;
               end
            end
            gpo_seq_pkg::ACT_FORCE_IDLE: begin
               cnt_state_next = gpo_seq_pkg::CNT_IDLE;
               field_cnt_next = 4'h0;
               wrap_next = 1'b0;
            end
            default: begin
            end
         endcase
      end
   end

   // Counter state registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_state_reg <= gpo_seq_pkg::CNT_IDLE;
         field_cnt_reg <= 4'h0;
         delay_cnt_reg <= 4'h0;
         wrap_reg <= 1'b0;
      end else if (clk_en) begin
         cnt_state_reg <= cnt_state_next;
         field_cnt_reg <= field_cnt_next;
         delay_cnt_reg <= delay_cnt_next;
         wrap_reg <= wrap_next;
      end
   end

   // Output one toggle unit
   toggle_output u_out_one (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .pos(pos),
      .sel(output_one_sequence_select),
      .counter_running(cnt_state_reg == gpo_seq_pkg::CNT_RUN),
      .tog_a(tog_reg[0]),
      .tog_b(tog_reg[1]),
      .wave(wave_one)
   );

   // Output two toggle unit
   toggle_output u_out_two (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .pos(pos),
      .sel(output_two_sequence_select),
      .counter_running(cnt_state_reg == gpo_seq_pkg::CNT_RUN),
      .tog_a(tog_reg[2]),
      .tog_b(tog_reg[3]),
      .wave(wave_two)
   );

   // Output pins registered
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         general_output_one <= 1'b0;
         general_output_two <= 1'b0;
      end else if (clk_en) begin
         general_output_one <= sel_table[0] ? table_out : wave_one;
         general_output_two <= sel_table[1] ? table_out : wave_two;
      end
   end
endmodule // field_toggle_output_sequencer
`default_nettype wire

// file: hw/gpo_seq_pkg.sv
// Purpose: Constants and types for the field toggle output sequencer.
// Assumes: One pixel clock domain, registers over a plain strobe port.
// Notes: Operation
package gpo_seq_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_TRIGGER = 8'h50;
   localparam logic [7:0] ADDR_COUNTER = 8'h51;
   localparam logic [7:0] ADDR_PROTOCOL = 8'h52;
   localparam logic [7:0] ADDR_TOG_BASE = 8'h54;
   localparam logic [7:0] ADDR_TOG_LAST = 8'h59;
   localparam logic [7:0] ADDR_STATUS = 8'h5A;
   // Counter register fields
   localparam int MAX_LSB = 0;
   localparam int DELAY_LSB = 4;
   // Protocol register fields
   localparam int PROT1_LSB = 0;
   localparam int PROT2_LSB = 2;
   localparam int SEL_LUT_LSB = 8;
   localparam int LUT_LSB = 10;
   // Toggle word fields
   localparam int PIX_LSB = 0;
   localparam int LINE_LSB = 13;
   localparam int FIELD_LSB = 26;
   // Reset values
   localparam logic [31:0] PROTOCOL_RST = 32'h0000_0000;
   localparam logic [31:0] TOGGLE_RST = 32'h0000_0000;
   localparam logic [7:0] COUNTER_RST = 8'h00;
   // Primary counter action codes
   localparam logic [2:0] ACT_IDLE = 3'h0;
   localparam logic [2:0] ACT_SINGLE = 3'h1;
   localparam logic [2:0] ACT_WRAP = 3'h2;
   localparam logic [2:0] ACT_DELAYED = 3'h3;
   localparam logic [2:0] ACT_FORCE_IDLE = 3'h7;

   // Output protocol selector
   typedef enum logic [1:0] {
      PROT_IDLE = 2'b00,
      PROT_MANUAL = 2'b01,
      PROT_LINKED = 2'b10,
      PROT_REPEAT = 2'b11
   } protocol_e;

   // Primary counter state
   typedef enum logic [1:0] {
      CNT_IDLE = 2'b00,
      CNT_DELAY = 2'b01,
      CNT_RUN = 2'b10
   } counter_e;

   // One toggle position
   typedef struct packed {
      logic [3:0] field;
      logic [12:0] line;
      logic [12:0] pixel;
   } toggle_s;

   // Field timing shared with toggle units
   typedef struct packed {
      logic [12:0] line;
      logic [12:0] pixel;
      logic [3:0] field;
      logic field_start;
   } position_s;
endpackage

// file: hw/toggle_output.sv
// Purpose: One general output waveform with two toggle points.
// Assumes: Position and field start come from the sequencer.
// Notes: Protocol armed at a field boundary, so selector changes act a field late.
`timescale 1ns/100ps
`default_nettype none
module toggle_output (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire gpo_seq_pkg::position_s pos,
   input wire gpo_seq_pkg::protocol_e sel,
   input wire logic counter_running,
   input wire gpo_seq_pkg::toggle_s tog_a,
   input wire gpo_seq_pkg::toggle_s tog_b,
   output logic wave
);
   // Protocol as latched at the last field boundary
   gpo_seq_pkg::protocol_e active_reg;
   // Set once idle has stood for a whole field
   logic rearm_ok_reg;
   // Field gating per protocol
   wire field_ok;
   wire hit_a;
   wire hit_b;
   wire fire;

   assign hit_a = pos.line == tog_a.line && pos.pixel == tog_a.pixel &&
                  (active_reg == gpo_seq_pkg::PROT_MANUAL ||
                   tog_a.field == pos.field);
   assign hit_b = pos.line == tog_b.line && pos.pixel == tog_b.pixel &&
                  (active_reg == gpo_seq_pkg::PROT_MANUAL ||
                   tog_b.field == pos.field);
   assign field_ok = active_reg == gpo_seq_pkg::PROT_MANUAL ||
                     ((active_reg == gpo_seq_pkg::PROT_LINKED ||
                       active_reg == gpo_seq_pkg::PROT_REPEAT) &&
                      counter_running);
   // Both toggles at one point cancel out
   assign fire = field_ok && (hit_a ^ hit_b);

   // Protocol latch and waveform
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         active_reg <= gpo_seq_pkg::PROT_IDLE;
         rearm_ok_reg <= 1'b1;
         wave <= 1'b0;
      end else if (clk_en) begin
         if (pos.field_start) begin
            if (sel == gpo_seq_pkg::PROT_IDLE) begin
               active_reg <= gpo_seq_pkg::PROT_IDLE;
               rearm_ok_reg <= active_reg == gpo_seq_pkg::PROT_IDLE;
               wave <= 1'b0;
            end else if (active_reg != gpo_seq_pkg::PROT_IDLE ||
                         rearm_ok_reg) begin
               active_reg <= sel;
            end
         end else if (fire) begin
            wave <= ~wave;
         end
      end
   end
endmodule // toggle_output
`default_nettype wire
